// ==== waveform_lut_temp_select.v ====
// temperature-driven waveform setting selector and loader
`timescale 1ns/1ps
`include "wlts_map.vh"
// How it works
// - voltage codes 00/01/10 pick ground, positive one, negative level
// - phase length zero skips phase, else lasts that many frames
// - repeat and state-repeat counts applied as stored value plus one
// - every group carries its own 3-bit frame-rate selector
// - gate-scan selector zero means ordinary scanning through the pair
// - gate-scan selector one holds all gates high through the pair
// - a waveform setting spans 159 bytes
// - bytes 0 to 152 hold the lookup tables
// - byte 153 holds the table end option
// - byte 154 holds gate level, same home as gate command
// - bytes 155 to 157 hold source levels, same home as source command
// - byte 158 holds common-electrode level
// - lookup contents load from memory or from host writes
// - temperature from internal sensor, external link or host
// - device masters the sensor link and reads temperature register
// - 12-bit temperature, top bit clear means positive sixteenths
// - top bit set means negative, two's complement sixteenths
// - scan ranges 0 to 35, keep last match, load its setting
// - match when lower < temperature <= upper
// - no match means no display update
// - memory holds 36 settings and 36 ranges
// - setting k at k*159; ranges from 5724 to 5831
// - range record byte layout of lower and upper limits
module waveform_lut_temp_select (
   input wire CLK, // 10 MHz clock
   input wire SRST, // synchronous reset, high
   input wire START, // pulse: sense temperature and load
   input wire [1:0] TEMP_SRC, // temperature source select
   input wire [11:0] INT_TEMP, // internal sensor reading
   input wire [11:0] HOST_TEMP, // host-supplied reading
   input wire HOST_WR, // host writes a setting byte
   input wire [7:0] HOST_IDX, // setting byte index
   input wire [7:0] HOST_DATA, // setting byte value
   input wire OTP_WR, // memory programming strobe
   input wire [12:0] OTP_WADDR, // memory programming address
   input wire [7:0] OTP_WDATA, // memory programming byte
   input wire [7:0] LUT_RIDX, // lookup byte to read back
   input wire [3:0] GRP_SEL, // group for decoded view
   input wire [1:0] PHASE_SEL, // phase for decoded view
   input wire [2:0] LUT_SEL, // table for decoded view
   input wire SENSOR_SDA_IN, // sensor link data level
   output reg SENSOR_SDA_OE, // sensor link data pull low
   output reg SENSOR_SCL_OE, // sensor link clock pull low
   output reg BUSY, // search or load in progress
   output reg DONE, // pulse: search finished
   output reg MATCH_FOUND, // last search matched a range
   output reg UPDATE_OK, // display update permitted
   output reg [5:0] SEL_IDX, // selected setting index
   output reg [11:0] TEMP_VAL, // temperature used
   output reg [7:0] LUT_RDATA, // lookup byte read back
   output reg [7:0] TABLE_END_OPTION_VAL, // table end option
   output reg [7:0] GATE_LVL, // gate driving level
   output reg [7:0] SRC_LVL0, // source positive level one
   output reg [7:0] SRC_LVL1, // source positive level two
   output reg [7:0] SRC_LVL2, // source negative level
   output reg [7:0] VCOM_LVL, // common dc level
   output reg [1:0] SRC_LEVEL, // decoded source level for view
   output reg [1:0] COM_LEVEL, // decoded common level for view
   output reg PHASE_SKIP, // viewed phase skipped
   output reg [8:0] GRP_PASSES, // viewed group passes
   output reg [8:0] PAIR_PASSES, // viewed pair passes
   output reg [2:0] FRAME_RATE, // viewed group frame rate
   output reg ALL_GATE_ON // viewed pair holds gates high
);
   localparam S_IDLE = 3'd0;
   localparam S_TEMP = 3'd1;
   localparam S_TR = 3'd2;
   localparam S_CMP = 3'd3;
   localparam S_WS = 3'd4;
   localparam S_FIN = 3'd5;
   // source output codes and common codes
   localparam LV_GND = 2'h0;
   localparam LV_POS1 = 2'h1;
   localparam LV_NEG = 2'h2;
   localparam LV_POS2 = 2'h3;
   localparam CM_DC = 2'h0;
   localparam CM_PLUS = 2'h1;
   localparam CM_MINUS = 2'h2;

   reg [2:0] state_r;
   reg [5:0] tr_idx_r;
   reg [1:0] tr_byte_r;
   reg [7:0] tr_b0_r;
   reg [7:0] tr_b1_r;
   reg rd_valid_r;
   reg [7:0] ws_byte_r;
   reg [7:0] ws_wr_idx_r;
   reg ws_wr_pend_r;
   reg [`ADDR_W-1:0] rd_addr_r;
   reg hit_r;
   reg [7:0] lut_r [0:`WS_BYTES-1];
   reg [7:0] otp_q_d;
   reg link_start_r;
   wire [7:0] otp_q;
   wire link_done;
   wire [11:0] link_temp;
   wire link_scl;
   wire link_sda;
   integer i;

   // ==================================================
   // helper functions
   // setting base address, k*159
   function [`ADDR_W-1:0] ws_base;
      input [5:0] k;
      begin
         ws_base = k * `WS_BYTES;
      end
   endfunction
   // range record base address
   function [`ADDR_W-1:0] tr_base;
      input [5:0] k;
      begin
         tr_base = `TR_BASE + k * `TR_BYTES;
      end
   endfunction
   // signed strict-less-than on 12-bit two's complement
   function slt12;
      input [11:0] a;
      input [11:0] b;
      begin
         slt12 = $signed(a) < $signed(b);
      end
   endfunction

   // ==================================================
   // memory and sensor link
   otp_store u_otp (
      .clk(CLK),
      .rd_addr(rd_addr_r),
      .rd_data(otp_q),
      .wr_en(OTP_WR),
      .wr_addr(OTP_WADDR),
      .wr_data(OTP_WDATA)
   );

   sensor_link u_link (
      .clk(CLK),
      .srst(SRST),
      .start(link_start_r),
      .busy(),
      .done(link_done),
      .temp(link_temp),
      .scl_oe(link_scl),
      .sda_oe(link_sda),
      .sda_in(SENSOR_SDA_IN)
   );

   // ==================================================
   // range comparison on the record just completed
   wire [11:0] lo_lim = {tr_b1_r[3:0], tr_b0_r};
   wire [11:0] hi_lim = {otp_q, tr_b1_r[7:4]};
   wire in_range = slt12(lo_lim, TEMP_VAL) && !slt12(hi_lim, TEMP_VAL);

   // ==================================================
   // search and load sequencer
   always @(posedge CLK) begin
      if (SRST) begin
         state_r <= S_IDLE;
         tr_idx_r <= 6'h00;
         tr_byte_r <= 2'h0;
         tr_b0_r <= 8'h00;
         tr_b1_r <= 8'h00;
         rd_valid_r <= 1'b0;
         ws_byte_r <= 8'h00;
         ws_wr_idx_r <= 8'h00;
         ws_wr_pend_r <= 1'b0;
         rd_addr_r <= {`ADDR_W{1'b0}};
         hit_r <= 1'b0;
         link_start_r <= 1'b0;
         BUSY <= 1'b0;
         DONE <= 1'b0;
         MATCH_FOUND <= 1'b0;
         UPDATE_OK <= 1'b0;
         SEL_IDX <= 6'h00;
         TEMP_VAL <= 12'h000;
      end else begin
         DONE <= 1'b0;
         link_start_r <= 1'b0;
         ws_wr_pend_r <= 1'b0;
         case (state_r)
            S_IDLE: begin
               if (START) begin
                  BUSY <= 1'b1;
                  state_r <= S_TEMP;
                  if (TEMP_SRC == `TSRC_EXT) begin
                     link_start_r <= 1'b1;
                  end
               end
            end
            S_TEMP: begin
               // source pick; link value arrives with its done pulse
               if (TEMP_SRC == `TSRC_EXT) begin
                  if (link_done) begin
                     TEMP_VAL <= link_temp;
                     state_r <= S_TR;
                  end
               end else begin
                  TEMP_VAL <= (TEMP_SRC == `TSRC_HOST) ? HOST_TEMP : INT_TEMP;
                  state_r <= S_TR;
               end
               tr_idx_r <= 6'h00;
               tr_byte_r <= 2'h0;
               hit_r <= 1'b0;
               rd_addr_r <= tr_base(6'h00);
               rd_valid_r <= 1'b0;
            end
            S_TR: begin
               // one address per cycle, data lands a cycle later
               rd_valid_r <= 1'b1;
               if (rd_valid_r) begin
                  if (tr_byte_r == 2'h0) begin
                     tr_b0_r <= otp_q;
                     tr_byte_r <= 2'h1;
                  end else begin
                     tr_b1_r <= otp_q;
                     tr_byte_r <= 2'h2;
                     state_r <= S_CMP;
                  end
               end
               if (tr_byte_r == 2'h0) begin
                  rd_addr_r <= rd_addr_r + 13'd1;
               end
            end
            S_CMP: begin
               // otp_q now holds byte two of the record
               if (in_range) begin
                  hit_r <= 1'b1;
                  SEL_IDX <= tr_idx_r; // last match wins
               end
               rd_valid_r <= 1'b0;
               tr_byte_r <= 2'h0;
               if (tr_idx_r == `TR_LAST_IDX) begin
                  if (in_range || hit_r) begin
                     rd_addr_r <= ws_base(in_range ? tr_idx_r : SEL_IDX);
                     ws_byte_r <= 8'h00;
                     state_r <= S_WS;
                  end else begin
                     state_r <= S_FIN;
                  end
               end else begin
                  tr_idx_r <= tr_idx_r + 6'h01;
                  rd_addr_r <= tr_base(tr_idx_r + 6'h01);
                  state_r <= S_TR;
               end
            end
            S_WS: begin
               // stream 159 bytes into the lookup registers
               rd_valid_r <= 1'b1;
               rd_addr_r <= rd_addr_r + 13'd1;
               if (rd_valid_r) begin
                  ws_wr_idx_r <= ws_byte_r;
                  ws_wr_pend_r <= 1'b1;
                  ws_byte_r <= ws_byte_r + 8'h01;
                  if (ws_byte_r == `WS_VCOM) begin
                     state_r <= S_FIN;
                  end
               end
            end
            S_FIN: begin
               MATCH_FOUND <= hit_r;
               UPDATE_OK <= hit_r;
               BUSY <= 1'b0;
               DONE <= 1'b1;
               state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // ==================================================
   // lookup registers: memory load has priority over host writes
   always @(posedge CLK) begin
      if (SRST) begin
         for (i = 0; i < `WS_BYTES; i = i + 1) begin
            lut_r[i] <= 8'h00;
         end
      end else if (ws_wr_pend_r) begin
         lut_r[ws_wr_idx_r] <= otp_q_d;
      end else if (HOST_WR && !BUSY && HOST_IDX <= `WS_VCOM) begin
         lut_r[HOST_IDX] <= HOST_DATA;
      end
   end

   // data delayed to align with the pending write
   always @(posedge CLK) begin
      otp_q_d <= otp_q;
   end

   // ==================================================
   // decode of the viewed group/phase/table
   wire [7:0] vs_byte = lut_r[{1'b0, LUT_SEL, 4'h0} - {1'b0, LUT_SEL, 2'h0} + {4'h0, GRP_SEL}];
   wire [1:0] vcode = vs_byte[7 - {PHASE_SEL, 1'b0} -: 2];
   wire [7:0] grp_base = 8'd60 + {GRP_SEL, 3'h0} - {4'h0, GRP_SEL}; // 7 bytes per group
   wire [7:0] tp_byte = lut_r[grp_base + {6'h00, PHASE_SEL} + {7'h00, PHASE_SEL[1]}];
   wire [7:0] sr_byte = lut_r[grp_base + (PHASE_SEL[1] ? 8'd5 : 8'd2)];
   wire [7:0] rp_byte = lut_r[grp_base + 8'd6];
   wire [7:0] fr_byte = lut_r[8'd144 + {5'h00, GRP_SEL[3:1]}];
   wire [7:0] xon_byte = lut_r[8'd150 + {6'h00, GRP_SEL[3:2]}];

   // ==================================================
   // registered outputs
   always @(posedge CLK) begin
      if (SRST) begin
         SENSOR_SDA_OE <= 1'b0;
         SENSOR_SCL_OE <= 1'b0;
         LUT_RDATA <= 8'h00;
         TABLE_END_OPTION_VAL <= 8'h00;
         GATE_LVL <= 8'h00;
         SRC_LVL0 <= 8'h00;
         SRC_LVL1 <= 8'h00;
         SRC_LVL2 <= 8'h00;
         VCOM_LVL <= 8'h00;
         SRC_LEVEL <= LV_GND;
         COM_LEVEL <= CM_DC;
         PHASE_SKIP <= 1'b1;
         GRP_PASSES <= 9'h001;
         PAIR_PASSES <= 9'h001;
         FRAME_RATE <= 3'h0;
         ALL_GATE_ON <= 1'b0;
      end else begin
         SENSOR_SDA_OE <= link_sda;
         SENSOR_SCL_OE <= link_scl;
         LUT_RDATA <= (LUT_RIDX <= `WS_VCOM) ? lut_r[LUT_RIDX] : 8'h00;
         TABLE_END_OPTION_VAL <= lut_r[`WS_TABLE_END_OPTION];
         GATE_LVL <= lut_r[`WS_GATE];
         SRC_LVL0 <= lut_r[`WS_SRC0];
         SRC_LVL1 <= lut_r[`WS_SRC0 + 8'd1];
         SRC_LVL2 <= lut_r[`WS_SRC2];
         VCOM_LVL <= lut_r[`WS_VCOM];
         case (vcode)
            `VC_GND: begin
               SRC_LEVEL <= LV_GND;
               COM_LEVEL <= CM_DC;
            end
            `VC_POS1: begin
               SRC_LEVEL <= LV_POS1;
               COM_LEVEL <= CM_PLUS;
            end
            `VC_NEG: begin
               SRC_LEVEL <= LV_NEG;
               COM_LEVEL <= CM_MINUS;
            end
            default: begin
               SRC_LEVEL <= LV_POS2;
               COM_LEVEL <= CM_DC;
            end
         endcase
         PHASE_SKIP <= (tp_byte == 8'h00);
         GRP_PASSES <= {1'b0, rp_byte} + 9'h001;
         PAIR_PASSES <= {1'b0, sr_byte} + 9'h001;
         FRAME_RATE <= GRP_SEL[0] ? fr_byte[2:0] : fr_byte[6:4];
         // 0 = ordinary scan, 1 = all gates high for the pair
         ALL_GATE_ON <= xon_byte[7 - {GRP_SEL[1:0], PHASE_SEL[1]}];
      end
   end
endmodule // waveform_lut_temp_select

// ==== wlts_map.vh ====
// constants for the waveform loader: memory map, setting layout, temperature format
`ifndef WLTS_MAP_VH
`define WLTS_MAP_VH
// ==================================================
// memory map
`define WS_BYTES 13'd159
`define WS_COUNT 6'd36
`define WS_LAST_ADDR 13'd5723
`define TR_BASE 13'd5724
`define TR_LAST_ADDR 13'd5831
`define TR_BYTES 13'd3
`define TR_LAST_IDX 6'd35
`define MEM_DEPTH 5832
`define ADDR_W 13
// ==================================================
// byte positions inside one waveform setting
`define WS_LUT_LAST 8'd152
`define WS_TABLE_END_OPTION 8'd153
`define WS_GATE 8'd154
`define WS_SRC0 8'd155
`define WS_SRC2 8'd157
`define WS_VCOM 8'd158
// ==================================================
// temperature sources
`define TSRC_INT 2'h0
`define TSRC_EXT 2'h1
`define TSRC_HOST 2'h2
// ==================================================
// sensor link: clock divider and sensor address
`define LINK_DIV 8'd24
`define SENSOR_ADDR 7'h48
`define TEMP_W 12
// ==================================================
// voltage codes
`define VC_GND 2'h0
`define VC_POS1 2'h1
`define VC_NEG 2'h2
`define VC_POS2 2'h3
`endif

// ==== otp_store.v ====
// one-time-programmable store with registered read data
`timescale 1ns/1ps
`include "wlts_map.vh"
module otp_store (
   input wire clk, // system clock
   input wire [`ADDR_W-1:0] rd_addr, // read address
   output reg [7:0] rd_data, // registered read byte
   input wire wr_en, // programming strobe
   input wire [`ADDR_W-1:0] wr_addr, // programming address
   input wire [7:0] wr_data // programming byte
);
   reg [7:0] mem [0:`MEM_DEPTH-1];
   // ==================================================
   // synchronous read, one cycle latency
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // otp_store

// ==== sensor_link.v ====
// single-master two-wire reader of an external temperature register
`timescale 1ns/1ps
`include "wlts_map.vh"
module sensor_link (
   input wire clk, // system clock
   input wire srst, // synchronous reset
   input wire start, // begin a read
   output reg busy, // read in progress
   output reg done, // one-cycle pulse, value valid
   output reg [11:0] temp, // value read
   output reg scl_oe, // drive clock low
   output reg sda_oe, // drive data low
   input wire sda_in // data line level
);
   localparam S_IDLE = 3'd0;
   localparam S_START = 3'd1;
   localparam S_BIT = 3'd2;
   localparam S_STOP = 3'd3;
   reg [2:0] state_r;
   reg [7:0] div_r;
   reg [1:0] qtr_r;
   reg [4:0] bit_r;
   reg [26:0] shift_r;
   reg [15:0] rx_r;
   wire tick = (div_r == `LINK_DIV);
   // ==================================================
   // frame: start, address+read, ack, two bytes with master ack/nack, stop
   always @(posedge clk) begin
      if (srst) begin
         state_r <= S_IDLE;
         div_r <= 8'h00;
         qtr_r <= 2'h0;
         bit_r <= 5'h00;
         shift_r <= 27'h0;
         rx_r <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
         temp <= 12'h000;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         done <= 1'b0;
         div_r <= tick ? 8'h00 : div_r + 8'h01;
         case (state_r)
            S_IDLE: begin
               if (start) begin
                  busy <= 1'b1;
                  // addr, R, ack slot(1), 8 released, mack(0), 8 released, nack(1)
                  shift_r <= {`SENSOR_ADDR, 1'b1, 1'b1, 8'hFF, 1'b0, 8'hFF, 1'b1};
                  bit_r <= 5'd0;
                  qtr_r <= 2'h0;
                  state_r <= S_START;
               end
            end
            S_START: if (tick) begin
               sda_oe <= 1'b1; // data falls while clock high
               state_r <= S_BIT;
            end
            S_BIT: if (tick) begin
               qtr_r <= qtr_r + 2'h1;
               case (qtr_r)
                  2'h0: scl_oe <= 1'b1;
                  2'h1: sda_oe <= ~shift_r[26];
                  2'h2: scl_oe <= 1'b0;
                  default: begin
                     if ((bit_r >= 5'd9 && bit_r <= 5'd16) || (bit_r >= 5'd18 && bit_r <= 5'd25)) begin
                        rx_r <= {rx_r[14:0], sda_in};
                     end
                     shift_r <= {shift_r[25:0], 1'b1};
                     bit_r <= bit_r + 5'd1;
                     if (bit_r == 5'd26) begin
                        state_r <= S_STOP;
                     end
                  end
               endcase
            end
            S_STOP: if (tick) begin
               qtr_r <= qtr_r + 2'h1;
               case (qtr_r)
                  2'h0: scl_oe <= 1'b1;
                  2'h1: sda_oe <= 1'b1;
                  2'h2: scl_oe <= 1'b0;
                  default: begin
                     sda_oe <= 1'b0; // stop: data rises with clock high
                     temp <= rx_r[15:4]; // left-justified 12-bit reading
                     done <= 1'b1;
                     busy <= 1'b0;
                     state_r <= S_IDLE;
                  end
               endcase
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule // sensor_link

// ==== wlts_checker.sv ====
// port assertions for the temperature-driven waveform loader
`timescale 1ns/1ps
module wlts_checker (
   input wire CLK, // clock
   input wire SRST, // sync reset
   input wire START, // start pulse
   input wire [1:0] TEMP_SRC, // source select
   input wire BUSY, // busy level
   input wire DONE, // done pulse
   input wire MATCH_FOUND, // match flag
   input wire UPDATE_OK, // update permit
   input wire [5:0] SEL_IDX, // chosen index
   input wire SENSOR_SCL_OE, // link clock pull
   input wire [8:0] GRP_PASSES, // group passes
   input wire [8:0] PAIR_PASSES // pair passes
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   // ==========
   // handshake: start, busy, done
   AST_DONE_PULSE: assert property (DONE |=> !DONE)
      else $error("done held longer than one cycle");
   AST_DONE_ENDS_BUSY: assert property (DONE |-> !BUSY && $past(BUSY))
      else $error("done without a preceding busy phase");
   AST_START_TAKEN: assert property (START && !BUSY |=> BUSY)
      else $error("start not taken");
   AST_IDLE_STAYS: assert property (!BUSY && !START |=> !BUSY)
      else $error("busy without a start");
   // a local search is 36 records plus one load when a range matches, far from a link frame
   AST_SEARCH_BOUND: assert property ($rose(BUSY) && TEMP_SRC != 2'h1 |-> ##[100:600] DONE)
      else $error("local search did not finish in time");
   // ==========
   // result flags, selected index, link clock and pass counts
   AST_NO_MATCH_NO_UPDATE: assert property (DONE |-> UPDATE_OK == MATCH_FOUND)
      else $error("update permit differs from match");
   AST_FLAGS_HOLD: assert property (!DONE |-> $stable(MATCH_FOUND) && $stable(UPDATE_OK))
      else $error("result flags changed outside done");
   AST_INDEX_RANGE: assert property (SEL_IDX <= 6'd35)
      else $error("selected index beyond last range");
   AST_LINK_ONLY_BUSY: assert property (SENSOR_SCL_OE |-> BUSY || $past(BUSY))
      else $error("link clock driven while idle");
   AST_PASSES_PLUS_ONE: assert property (GRP_PASSES != 9'h000 && PAIR_PASSES != 9'h000)
      else $error("zero passes reported");
endmodule // wlts_checker
bind waveform_lut_temp_select wlts_checker wlts_checker_i (.CLK(CLK), .SRST(SRST),
   .START(START), .TEMP_SRC(TEMP_SRC), .BUSY(BUSY), .DONE(DONE),
   .MATCH_FOUND(MATCH_FOUND), .UPDATE_OK(UPDATE_OK), .SEL_IDX(SEL_IDX),
   .SENSOR_SCL_OE(SENSOR_SCL_OE), .GRP_PASSES(GRP_PASSES), .PAIR_PASSES(PAIR_PASSES));

// ==== temp_sensor_model.sv ====
// two-wire temperature sensor answering a two-byte register read
`timescale 1ns/1ps
module temp_sensor_model (
   input wire scl, // clock line level
   input wire sda, // data line level
   input wire [15:0] value, // register content
   output reg sda_oe // pull data low
);
   integer cnt;
   // ==========
   // bit counter restarted by a start condition
   initial begin
      cnt = 99;
      sda_oe = 1'b0;
   end
   always @(negedge sda) if (scl) cnt = 0;
   always @(posedge scl) cnt = cnt + 1;
   // change data only while clock is low; released line floats to pull-up
   always @(negedge scl) begin
      if (cnt == 8) sda_oe <= 1'b1;
      else if (cnt >= 9 && cnt <= 16) sda_oe <= ~value[24-cnt];
      else if (cnt >= 18 && cnt <= 25) sda_oe <= ~value[25-cnt];
      else sda_oe <= 1'b0;
   end
endmodule // temp_sensor_model

// ==== tb.sv ====
// self-checking bench for the waveform loader
`timescale 1ns/1ps
module tb;
   reg clk, srst, start, host_wr, otp_wr;
   reg [1:0] temp_src, phase_sel;
   reg [11:0] int_temp, host_temp;
   reg [7:0] host_idx, host_data, otp_wdata, lut_ridx;
   reg [12:0] otp_waddr;
   reg [3:0] grp_sel;
   reg [2:0] lut_sel;
   reg [15:0] ext_val;
   wire sda_oe, scl_oe, dev_oe, busy, done, mf, uok, ph_skip, ago;
   wire [5:0] sel_idx;
   wire [11:0] temp_val;
   wire [7:0] lut_rdata, table_end_option, gate, s0, s1, s2, vcom;
   wire [1:0] src_lv, com_lv;
   wire [8:0] gp, pp;
   wire [2:0] fr;
   wire scl = ~scl_oe;
   wire sda = ~(sda_oe | dev_oe);
   integer mismatches, check_count, i, j, lastk;
   waveform_lut_temp_select waveform_lut_temp_select_i (.CLK(clk), .SRST(srst),
      .START(start), .TEMP_SRC(temp_src), .INT_TEMP(int_temp), .HOST_TEMP(host_temp),
      .HOST_WR(host_wr), .HOST_IDX(host_idx), .HOST_DATA(host_data), .OTP_WR(otp_wr),
      .OTP_WADDR(otp_waddr), .OTP_WDATA(otp_wdata), .LUT_RIDX(lut_ridx),
      .GRP_SEL(grp_sel), .PHASE_SEL(phase_sel), .LUT_SEL(lut_sel), .SENSOR_SDA_IN(sda),
      .SENSOR_SDA_OE(sda_oe), .SENSOR_SCL_OE(scl_oe), .BUSY(busy), .DONE(done),
      .MATCH_FOUND(mf), .UPDATE_OK(uok), .SEL_IDX(sel_idx), .TEMP_VAL(temp_val),
      .LUT_RDATA(lut_rdata), .TABLE_END_OPTION_VAL(table_end_option), .GATE_LVL(gate), .SRC_LVL0(s0),
      .SRC_LVL1(s1), .SRC_LVL2(s2), .VCOM_LVL(vcom), .SRC_LEVEL(src_lv),
      .COM_LEVEL(com_lv), .PHASE_SKIP(ph_skip), .GRP_PASSES(gp), .PAIR_PASSES(pp),
      .FRAME_RATE(fr), .ALL_GATE_ON(ago));
   temp_sensor_model temp_sensor_model_i (.scl(scl), .sda(sda), .value(ext_val),
      .sda_oe(dev_oe));
   // ==========
   // helpers
   function [7:0] f(input integer k, input integer b);
      f = k * 5 + b;
   endfunction
   function [7:0] e(input integer b);
      e = (lastk < 0) ? 8'h00 : f(lastk, b);
   endfunction
   task chk(input [79:0] name, input [11:0] seen, input [11:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // strobe stays high across back-to-back writes
   task otp_w(input integer a, input [7:0] d);
      begin
         @(negedge clk);
         otp_wr = 1'b1;
         otp_waddr = a;
         otp_wdata = d;
      end
   endtask
   task tr(input integer n, input [11:0] lo, input [11:0] hi);
      begin
         otp_w(5724 + 3 * n, lo[7:0]);
         otp_w(5725 + 3 * n, {hi[3:0], lo[11:8]});
         otp_w(5726 + 3 * n, hi[11:4]);
         @(negedge clk);
         otp_wr = 1'b0;
      end
   endtask
   task hw(input [7:0] a, input [7:0] d);
      begin
         @(negedge clk);
         host_wr = 1'b1;
         host_idx = a;
         host_data = d;
      end
   endtask
   // ==========
   // one temperature search, judged on flags and loaded bytes
   task srch(input [1:0] src, input [11:0] t, input integer k, input m);
      integer n;
      begin
         @(negedge clk);
         temp_src = src;
         int_temp = (src == 2'h0 || src == 2'h3) ? t : 12'h800;
         host_temp = (src == 2'h2) ? t : 12'h800;
         ext_val = (src == 2'h1) ? {t, 4'h0} : 16'h8000;
         start = 1'b1;
         @(negedge clk);
         start = 1'b0;
         chk("busy", busy, 1'b1);
         n = 0;
         while (done !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n = n + 1;
         end
         if (n == 9000) mismatches = mismatches + 1;
         chk("match", mf, m);
         chk("update", uok, m);
         chk("temp", temp_val, t);
         if (m) lastk = k;
         if (m) chk("index", sel_idx, k);
         lut_ridx = 8'h00;
         @(negedge clk);
         chk("table_end_option", table_end_option, e(153));
         chk("gate", gate, e(154));
         chk("src0", s0, e(155));
         chk("src1", s1, e(156));
         chk("src2", s2, e(157));
         chk("vcom", vcom, e(158));
         chk("lut0", lut_rdata, e(0));
         lut_ridx = 8'h98;
         @(negedge clk);
         chk("lut152", lut_rdata, e(152));
         $display("search src %0d temp %h finished", src, t);
      end
   endtask
   // host-written lookup bytes and the decoded view
   task t_view;
      begin
         hw(8'h00, 8'h6C);
         hw(8'h3C, 8'h00);
         hw(8'h3D, 8'h05);
         hw(8'h3E, 8'hFF);
         hw(8'h42, 8'h00);
         hw(8'h90, 8'h70);
         hw(8'h96, 8'h80);
         hw(8'h9A, 8'h5A);
         @(negedge clk);
         host_wr = 1'b0;
         lut_sel = 3'h0;
         grp_sel = 4'h0;
         phase_sel = 2'h0;
         lut_ridx = 8'h9F;
         repeat (2) @(negedge clk);
         chk("gatew", gate, 8'h5A);
         chk("ridx", lut_rdata, 8'h00);
         chk("srcA", src_lv, 2'h1);
         chk("comA", com_lv, 2'h1);
         chk("skipA", ph_skip, 1'b1);
         chk("pairp", pp, 9'h100);
         chk("grpp", gp, 9'h001);
         chk("frate", fr, 3'h7);
         chk("gateon", ago, 1'b1);
         phase_sel = 2'h1;
         repeat (2) @(negedge clk);
         chk("srcB", src_lv, 2'h2);
         chk("comB", com_lv, 2'h2);
         chk("skipB", ph_skip, 1'b0);
         phase_sel = 2'h3;
         repeat (2) @(negedge clk);
         chk("srcD", src_lv, 2'h0);
         chk("scanD", ago, 1'b0);
         $display("host write and view finished");
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   // ==========
   // clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #(60000 * 100);
      mismatches = mismatches + 1;
      end_of_test;
   end
   initial begin
      {srst, start, host_wr, otp_wr} = 4'hF;
      {start, host_wr, otp_wr} = 3'h0;
      {temp_src, phase_sel, grp_sel, lut_sel} = 11'h000;
      {int_temp, host_temp, ext_val} = 40'h0;
      {host_idx, host_data, otp_wdata, lut_ridx, otp_waddr} = 45'h0;
      {mismatches, check_count} = 64'h0;
      lastk = -1;
      repeat (4) @(negedge clk);
      srst = 1'b0;
      for (i = 0; i < 36; i = i + 1)
         for (j = 0; j < 159; j = j + 1) otp_w(i * 159 + j, f(i, j));
      for (i = 0; i < 36; i = i + 1) tr(i, 12'h000, 12'h000);
      srch(2'h0, 12'h190, 0, 1'b0);
      tr(0, 12'h800, 12'h050);
      tr(3, 12'h0F0, 12'h140);
      tr(4, 12'h140, 12'h190);
      tr(6, 12'h1E0, 12'h230);
      tr(7, 12'h210, 12'h7FF);
      srch(2'h0, 12'h190, 4, 1'b1);
      srch(2'h2, 12'h140, 3, 1'b1);
      srch(2'h0, 12'h220, 7, 1'b1);
      srch(2'h2, 12'hFFC, 0, 1'b1);
      srch(2'h1, 12'h190, 4, 1'b1);
      srch(2'h3, 12'h7FF, 7, 1'b1);
      tr(35, 12'h800, 12'h7FF);
      srch(2'h0, 12'hE70, 35, 1'b1);
      srch(2'h0, 12'h800, 0, 1'b0);
      t_view;
      end_of_test;
   end
endmodule // tb
